// *** pkg/door_alarm_params.svh ***
// constants for the door alarm and parameter entry block
`ifndef DOOR_ALARM_PARAMS_SVH
`define DOOR_ALARM_PARAMS_SVH
// ------------------------------------------------------------
// clock and times
// ------------------------------------------------------------
`define CLK_HZ 40000000
`define DEB_MS 20
`define REP_MS 250
`define BEEP_MS 200
`define DR_SHOW_S 30
`define HOLD_S 3
`define LOCK_SHOW_S 1
`define NAME_SHOW_S 1
`define SEC_PER_MIN 60
// ------------------------------------------------------------
// register offsets and fields
// ------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_LOCK 8'h04
`define REG_STATUS 8'h08
`define REG_PARAM 8'h40
`define CTRL_BUZZ 0
`define BUZZ_RST 1'b1
// ------------------------------------------------------------
// keys and pin vector positions
// ------------------------------------------------------------
`define KEY_POWER 0
`define KEY_UP 1
`define KEY_DOWN 2
`define KEY_ACCEPT 3
`define KEY_LIGHT 4
`define PIN_DOOR 6
// ------------------------------------------------------------
// parameter indices, in entry order
// ------------------------------------------------------------
`define P_DEF_INT 4'h0
`define P_MAX_DEF 4'h1
`define P_MIN_OFF 4'h2
`define P_DRIP 4'h3
`define P_WIN_DRY 4'h4
`define P_MAX_ON 4'h5
`define P_REST 4'h6
`define P_FB_ON 4'h7
`define P_FB_OFF 4'h8
`define P_SP_FLOOR 4'h9
`define P_SP_CEIL 4'hA
`define P_DEF_END 4'hB
`define P_RELAY4 4'hC
`define P_DOOR_TYPE 4'hD
`define P_LIGHT_SRC 4'hE
`define P_DOOR_DLY 4'hF
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_DEF_INT 8'h06
`define RST_MAX_DEF 8'h1E
`define RST_MIN_OFF 8'h03
`define RST_DRIP 8'h02
`define RST_WIN_DRY 8'h05
`define RST_MAX_ON 8'h28
`define RST_REST 8'h0A
`define RST_FB_ON 8'h19
`define RST_FB_OFF 8'h05
`define RST_SP_FLOOR 8'h01
`define RST_SP_CEIL 8'h0A
`define RST_DEF_END 8'h05
`define RST_RELAY4 8'h01
`define RST_DOOR_TYPE 8'h01
`define RST_LIGHT_SRC 8'h03
`define RST_DOOR_DLY 8'h01
// ------------------------------------------------------------
// value limits (two's complement)
// ------------------------------------------------------------
`define V_NONE 8'hFF
`define V_ZERO 8'h00
`define V_ONE 8'h01
`define MAX_DEF_INT 8'h18
`define MAX_99 8'h63
`define MAX_15 8'h0F
`define MAX_60 8'h3C
`define MIN_FLOOR 8'hD8
`define MAX_FLOOR 8'h14
`define MAX_CEIL 8'h27
`define MAX_DEF_END 8'h28
`define MAX_RELAY4 8'h04
`define MAX_DOOR_TYPE 8'h03
`define MAX_LIGHT_SRC 8'h03
`define MAX_DOOR_DLY 8'h14
`endif

// *** pkg/door_alarm_pkg.sv ***
// types of the door alarm and parameter entry block
package door_alarm_pkg;
	typedef enum logic [4:0] {
		M_RUN = 5'h01,
		M_HOLD = 5'h02,
		M_NAME = 5'h04,
		M_VALUE = 5'h08,
		M_LOCK = 5'h10
	} mode_t;
	typedef enum logic [2:0] {
		MSG_OFF = 3'h0,
		MSG_TEMP = 3'h1,
		MSG_DOOR = 3'h2,
		MSG_NAME = 3'h3,
		MSG_VALUE = 3'h4,
		MSG_LOCKED = 3'h5
	} msg_t;
	typedef struct packed {
		logic [6:0] s1;
		logic [6:0] s2;
		logic [6:0] samp;
		logic [6:0] stab;
		logic [6:0] prev;
		logic [25:0] dcnt;
		logic [25:0] scnt;
		logic [25:0] bcnt;
		logic [25:0] rcnt;
		logic [27:0] mcnt;
		logic door;
		logic dr;
		logic alarm;
		logic sil;
		logic [10:0] open_s;
		logic [4:0] beep_s;
		mode_t mode;
		logic [3:0] idx;
		logic [7:0] edit;
		logic unit_on;
		logic lkey;
		logic light;
		logic rl4;
		logic buzz;
		logic buzz_fit;
		logic [15:0] lock;
		logic [15:0][7:0] prm;
		msg_t msg;
		logic [7:0] dval;
		logic dflash;
		logic ledf;
		logic awv;
		logic [7:0] awa;
		logic wv;
		logic [31:0] wd;
		logic [3:0] ws;
		logic bv;
		logic [1:0] br;
		logic rv;
		logic [31:0] rd;
		logic [1:0] rr;
	} st_t;
endpackage

// *** tb/door_alarm_and_param_entry_bench.sv ***
// bench of the door alarm and parameter entry block
`timescale 1ns/1ps
`default_nettype none
module door_alarm_and_param_entry_bench;
	import door_alarm_pkg::*;
	logic clk_sys = 1'b0, rstn = 1'b0, door_open = 1'b0, comp_demand = 1'b0;
	logic ce = 1'b1;
	logic [1:0] door_type = 2'h1;
	logic [5:0] keys = 6'h00, key_pin;
	logic door_pin, fan_stop, comp_off, light_on, relay4_on, buzzer, unit_on;
	logic disp_flash, led_flash, awready, wready, bvalid, arready, rvalid;
	msg_t disp_msg;
	logic [7:0] disp_value, awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp, r;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, buz_q = 1'b0;
	logic [31:0] d;
	int fail_count = 0, num_checks = 0, cyc = 0, rises = 0;
	always #12.5 clk_sys = ~clk_sys;
	door_keypad_model model (.door_open(door_open), .door_type(door_type),
		.keys(keys), .door_pin(door_pin), .key_pin(key_pin));
	door_alarm_and_param_entry #(.SEC_CYC(100), .DEB_CYC(4), .REP_CYC(20),
		.BEEP_CYC(10)) dut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
		.door_pin(door_pin), .key_pin(key_pin), .comp_demand(comp_demand),
		.fan_stop(fan_stop), .comp_off(comp_off), .light_on(light_on),
		.relay4_on(relay4_on), .buzzer(buzzer), .unit_on(unit_on),
		.disp_msg(disp_msg), .disp_value(disp_value), .disp_flash(disp_flash),
		.led_flash(led_flash), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	// ------------------------------------------------------------
	// timeout and buzzer rise counter
	// ------------------------------------------------------------
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		buz_q <= buzzer;
		if (buzzer === 1'b1 && buz_q === 1'b0)
			rises <= rises + 1;
		if (cyc == 20000) begin
			fail_count++;
			complete_run();
		end
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw, tb;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk_sys);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			r = bresp;
			@(posedge clk_sys);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
		end while (!tb);
	endtask
	task automatic rd(input logic [7:0] a);
		logic ta, tr;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk_sys);
			ta = arvalid & arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk_sys);
			if (ta)
				arvalid <= 1'b0;
		end while (!tr);
	endtask
	task automatic keyhold(input logic [5:0] k, input int n);
		keys <= k;
		repeat (n) @(posedge clk_sys);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_ranges;
		logic [3:0] ix [10] = '{2, 4, 5, 6, 8, 10, 11, 15, 0, 1};
		logic [7:0] wv [10] = '{8'h20, 8'h50, 8'h70, 8'h70, 8'h00, 8'h30,
			8'h30, 8'h30, 8'h19, 8'hFF};
		logic [7:0] ev [10] = '{8'h0F, 8'h3C, 8'h63, 8'h63, 8'h01, 8'h27,
			8'h28, 8'h14, 8'h18, 8'hFF};
		rd(8'h7C);
		chk("delay reset", 32'h01, {24'h0, d[7:0]});
		for (int i = 0; i < 10; i++) begin
			wr(8'h40 + {2'h0, ix[i], 2'h0}, {24'h0, wv[i]});
			rd(8'h40 + {2'h0, ix[i], 2'h0});
			chk("param", {24'h0, ev[i]}, {24'h0, d[7:0]});
		end
		rd(8'h0C);
		chk("unmapped resp", 32'h2, {30'h0, r});
		wr(8'h0C, 32'h0);
		chk("unmapped wr resp", 32'h2, {30'h0, r});
		ce <= 1'b0;
		@(posedge clk_sys);
		chk("frozen ready", 32'h0, {31'h0, awready});
		ce <= 1'b1;
	endtask
	task automatic t_relay4;
		logic [7:0] sel [3] = '{8'h01, 8'h02, 8'h00};
		logic ex [3] = '{1'b1, 1'b1, 1'b0};
		comp_demand <= 1'b1;
		keyhold(6'h01, 20);
		keyhold(6'h00, 20);
		chk("unit on", 32'h1, {31'h0, unit_on});
		for (int i = 0; i < 3; i++) begin
			wr(8'h70, {24'h0, sel[i]});
			repeat (4) @(posedge clk_sys);
			chk("relay4", {31'h0, ex[i]}, {31'h0, relay4_on});
			comp_demand <= (i == 0) ? 1'b0 : 1'b1;
		end
	endtask
	task automatic t_door_now;
		wr(8'h74, 32'h1);
		wr(8'h7C, 32'h0);
		door_open <= 1'b1;
		repeat (20) @(posedge clk_sys);
		chk("fan stop", 32'h1, {31'h0, fan_stop});
		chk("light", 32'h1, {31'h0, light_on});
		chk("alarm comp", 32'h1, {31'h0, comp_off});
		chk("alarm buzz", 32'h1, {31'h0, buzzer});
		keyhold(6'h08, 20);
		chk("silenced", 32'h0, {31'h0, buzzer});
		keys <= 6'h00;
		door_open <= 1'b0;
		repeat (20) @(posedge clk_sys);
		chk("closed fan", 32'h0, {31'h0, fan_stop});
		chk("closed comp", 32'h0, {31'h0, comp_off});
	endtask
	task automatic t_door_slow;
		wr(8'h7C, 32'h1);
		wr(8'h78, 32'h2);
		// pin level stays put while the model flips polarity
		door_type <= 2'h2;
		door_open <= 1'b1;
		rises = 0;
		wr(8'h74, 32'h2);
		repeat (20) @(posedge clk_sys);
		chk("type2 fan", 32'h1, {31'h0, fan_stop});
		chk("key light", 32'h0, {31'h0, light_on});
		repeat (3000) @(posedge clk_sys);
		chk("door msg", MSG_DOOR, disp_msg);
		chk("steady", 32'h0, {31'h0, disp_flash});
		chk("no alarm yet", 32'h0, {31'h0, comp_off});
		chk("one beep", 32'h1, rises);
		repeat (3100) @(posedge clk_sys);
		chk("alarm flash", 32'h1, {31'h0, disp_flash});
		chk("alarm comp", 32'h1, {31'h0, comp_off});
		chk("alarm buzz", 32'h1, {31'h0, buzzer});
		door_open <= 1'b0;
		repeat (20) @(posedge clk_sys);
		chk("cleared", 32'h0, {31'h0, comp_off});
	endtask
	task automatic t_entry;
		wr(8'h04, 32'h2);
		keyhold(6'h01, 20);
		keyhold(6'h00, 20);
		chk("unit off", 32'h0, {31'h0, unit_on});
		keyhold(6'h06, 20);
		keyhold(6'h07, 100);
		keyhold(6'h00, 400);
		chk("aborted", 32'h0, {31'h0, led_flash});
		keyhold(6'h06, 20);
		keyhold(6'h07, 330);
		chk("leds", 32'h1, {31'h0, led_flash});
		chk("name", MSG_NAME, disp_msg);
		keyhold(6'h00, 120);
		chk("value", 32'h18, {24'h0, disp_value});
		keyhold(6'h04, 12);
		chk("down", 32'h17, {24'h0, disp_value});
		keyhold(6'h00, 20);
		keyhold(6'h08, 12);
		keyhold(6'h00, 20);
		chk("next", 32'h1, {24'h0, disp_value});
		keyhold(6'h00, 120);
		keyhold(6'h02, 12);
		chk("locked", MSG_LOCKED, disp_msg);
		keyhold(6'h00, 20);
		rd(8'h40);
		chk("stored", 32'h17, {24'h0, d[7:0]});
		rd(8'h44);
		chk("refused", 32'hFF, {24'h0, d[7:0]});
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		t_ranges();
		t_relay4();
		t_door_now();
		t_door_slow();
		t_entry();
		complete_run();
	end
endmodule
`default_nettype wire

// *** tb/door_keypad_model.sv ***
// door contact and keypad seen from the pin side
`timescale 1ns/1ps
`default_nettype none
module door_keypad_model (
	// commands from the bench
	input wire logic door_open,
	input wire logic [1:0] door_type,
	input wire logic [5:0] keys,
	// pins toward the block
	output logic door_pin,
	output logic [5:0] key_pin
);
	// type 01 contact closes on open, type 02 opens on open
	assign door_pin = (door_type == 2'h2) ? ~door_open : door_open;
	assign key_pin = keys;
endmodule
`default_nettype wire

// *** verilog/door_alarm_and_param_entry.sv ***
// door alarm supervisor and keypad parameter entry with register slave
//
// How it works
// - door open stops the fan at once; light follows light source select.
// - door open 30 s unbroken shows the door message steadily while the unit is on.
// - with buzzer fitted, short beep at message and every 30 s after.
// - past door alarm delay: flash display, buzzer on, compressor off.
// - door alarm delay zero raises the alarm as the door opens.
// - any key press silences an active door alarm.
// - door closing clears the alarm and restores normal operation.
// - door input type 01 contact closes on open, 02 opens on open.
// - unit off, hold up and down, press power, hold 3 s; release aborts.
// - entry flashes key LEDs and first name, then shows stored value.
// - up and down step with auto repeat; accept stores and advances.
// - locked parameter refuses change and shows locked symbol 1 s.
// - defrost interval 0 to 24 h, 0 manual only, -01 none.
// - max defrost time 0 to 99 min, -01 unlimited.
// - compressor off time and drip time 0 to 15 min.
// - window dry time 0 to 60 min, zero unlimited.
// - max compressor run 0 to 99 min, zero disables protection.
// - rest after run protection 0 to 99 min.
// - fallback on 1 to 99 min, fallback off 1 to 60 min.
// - setpoint floor up to 20 C, ceiling floor plus one to 39 C.
// - defrost end temperature 0 to 40 C.
// - relay four: 00 none, 01 fan with compressor, 02 fan always.
// - door alarm delay 0 to 20 min in minute steps.
// - light by door for 01, by keypad for 02, by both for 03.
`include "door_alarm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module door_alarm_and_param_entry #(
	parameter int SEC_CYC = `CLK_HZ,
	parameter int DEB_CYC = `CLK_HZ / 1000 * `DEB_MS,
	parameter int REP_CYC = `CLK_HZ / 1000 * `REP_MS,
	parameter int BEEP_CYC = `CLK_HZ / 1000 * `BEEP_MS
) (
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	// pins and regulation demand
	input wire logic door_pin,
	input wire logic [5:0] key_pin,
	input wire logic comp_demand,
	// loads and panel
	output logic fan_stop,
	output logic comp_off,
	output logic light_on,
	output logic relay4_on,
	output logic buzzer,
	output logic unit_on,
	output door_alarm_pkg::msg_t disp_msg,
	output logic [7:0] disp_value,
	output logic disp_flash,
	output logic led_flash,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import door_alarm_pkg::*;
	localparam int HOLD_CYC = `HOLD_S * SEC_CYC;
	localparam int NAME_CYC = `NAME_SHOW_S * SEC_CYC;
	localparam int LOCK_CYC = `LOCK_SHOW_S * SEC_CYC;
	localparam logic [15:0][7:0] PRM_RST = {`RST_DOOR_DLY,
		`RST_LIGHT_SRC, `RST_DOOR_TYPE, `RST_RELAY4, `RST_DEF_END,
		`RST_SP_CEIL, `RST_SP_FLOOR, `RST_FB_OFF, `RST_FB_ON, `RST_REST,
		`RST_MAX_ON, `RST_WIN_DRY, `RST_DRIP, `RST_MIN_OFF,
		`RST_MAX_DEF, `RST_DEF_INT};

	st_t st_reg;
	st_t st_next;
	logic tick;
	logic [6:0] press;
	logic door_now;
	logic up_k;
	logic dn_k;
	logic do_step;
	logic [10:0] alarm_s;

	// ------------------------------------------------------------
	// value limits
	// ------------------------------------------------------------
	function automatic logic signed [7:0] lo_f(input logic [3:0] i,
		input logic signed [7:0] floor_v);
		unique case (i)
			`P_DEF_INT, `P_MAX_DEF: lo_f = `V_NONE;
			`P_FB_ON, `P_FB_OFF: lo_f = `V_ONE;
			`P_SP_FLOOR: lo_f = `MIN_FLOOR;
			`P_SP_CEIL: lo_f = 8'(floor_v + 8'sh01);
			`P_LIGHT_SRC: lo_f = `V_ONE;
			default: lo_f = `V_ZERO;
		endcase
	endfunction

	function automatic logic signed [7:0] hi_f(input logic [3:0] i);
		unique case (i)
			`P_DEF_INT: hi_f = `MAX_DEF_INT;
			`P_MAX_DEF, `P_MAX_ON, `P_REST: hi_f = `MAX_99;
			`P_MIN_OFF, `P_DRIP: hi_f = `MAX_15;
			`P_WIN_DRY: hi_f = `MAX_60;
			`P_FB_ON: hi_f = `MAX_99;
			`P_FB_OFF: hi_f = `MAX_60;
			`P_SP_FLOOR: hi_f = `MAX_FLOOR;
			`P_SP_CEIL: hi_f = `MAX_CEIL;
			`P_DEF_END: hi_f = `MAX_DEF_END;
			`P_RELAY4: hi_f = `MAX_RELAY4;
			`P_DOOR_TYPE: hi_f = `MAX_DOOR_TYPE;
			`P_LIGHT_SRC: hi_f = `MAX_LIGHT_SRC;
			default: hi_f = `MAX_DOOR_DLY;
		endcase
	endfunction

	function automatic logic [7:0] clamp_f(input logic [3:0] i,
		input logic signed [7:0] v, input logic signed [7:0] floor_v);
		logic signed [7:0] l;
		logic signed [7:0] h;
		l = lo_f(i, floor_v);
		h = hi_f(i);
		clamp_f = (v < l) ? l : ((v > h) ? h : v);
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	assign tick = st_reg.scnt == 26'(SEC_CYC - 1);
	assign press = st_reg.stab & ~st_reg.prev;
	assign up_k = st_reg.stab[`KEY_UP];
	assign dn_k = st_reg.stab[`KEY_DOWN];
	assign alarm_s = 11'(st_reg.prm[`P_DOOR_DLY] * `SEC_PER_MIN);

	always_comb begin
		st_next = st_reg;
		do_step = 1'b0;
		st_next.s1 = {door_pin, key_pin};
		st_next.s2 = st_reg.s1;
		st_next.prev = st_reg.stab;
		// a level is taken only after two equal samples a period apart
		if (st_reg.dcnt == 26'(DEB_CYC - 1)) begin
			st_next.dcnt = '0;
			st_next.samp = st_reg.s2;
			st_next.stab = (st_reg.stab & (st_reg.samp ^ st_reg.s2))
				| (st_reg.s2 & ~(st_reg.samp ^ st_reg.s2));
		end else begin
			st_next.dcnt = st_reg.dcnt + 26'h1;
		end
		st_next.scnt = tick ? '0 : st_reg.scnt + 26'h1;
		if (st_reg.bcnt != '0) begin
			st_next.bcnt = st_reg.bcnt - 26'h1;
		end
		// door contact sense
		unique case (st_reg.prm[`P_DOOR_TYPE])
			8'h01: door_now = st_reg.stab[`PIN_DOOR];
			8'h02: door_now = ~st_reg.stab[`PIN_DOOR];
			default: door_now = 1'b0;
		endcase
		if (door_now && !st_reg.door) begin
			st_next.door = 1'b1;
			st_next.open_s = '0;
			st_next.beep_s = '0;
			st_next.alarm = st_reg.prm[`P_DOOR_DLY] == 8'h00;
			st_next.sil = 1'b0;
		end else if (!door_now) begin
			st_next.door = 1'b0;
			st_next.dr = 1'b0;
			st_next.alarm = 1'b0;
			st_next.sil = 1'b0;
		end else if (tick) begin
			if (st_reg.open_s != 11'h7FF) begin
				st_next.open_s = st_reg.open_s + 11'h1;
			end
			st_next.beep_s = st_reg.beep_s + 5'h1;
			if (st_reg.beep_s == 5'(`DR_SHOW_S - 1)) begin
				st_next.beep_s = '0;
				st_next.dr = 1'b1;
				st_next.bcnt = 26'(BEEP_CYC);
			end
			if (st_reg.open_s + 11'h1 >= alarm_s) begin
				st_next.alarm = 1'b1;
			end
		end
		if (st_reg.alarm && press[5:0] != '0) begin
			st_next.sil = 1'b1;
		end
		if (press[`KEY_LIGHT]) begin
			st_next.lkey = ~st_reg.lkey;
		end
		// ------------------------------------------------------------
		// parameter entry
		// ------------------------------------------------------------
		unique case (st_reg.mode)
			M_RUN: begin
				if (press[`KEY_POWER] && up_k && dn_k && !st_reg.unit_on) begin
					st_next.mode = M_HOLD;
					st_next.mcnt = '0;
				end else if (press[`KEY_POWER]) begin
					st_next.unit_on = ~st_reg.unit_on;
				end
			end
			M_HOLD: begin
				if (!(st_reg.stab[`KEY_POWER] && up_k && dn_k)) begin
					st_next.mode = M_RUN;
				end else if (st_reg.mcnt == 28'(HOLD_CYC - 1)) begin
					st_next.mode = M_NAME;
					st_next.idx = `P_DEF_INT;
					st_next.mcnt = '0;
				end else begin
					st_next.mcnt = st_reg.mcnt + 28'h1;
				end
			end
			M_NAME: begin
				if (st_reg.mcnt == 28'(NAME_CYC - 1)) begin
					st_next.mode = M_VALUE;
					st_next.edit = st_reg.prm[st_reg.idx];
				end else begin
					st_next.mcnt = st_reg.mcnt + 28'h1;
				end
			end
			M_VALUE: begin
				if (press[`KEY_UP] || press[`KEY_DOWN]) begin
					if (st_reg.lock[st_reg.idx]) begin
						st_next.mode = M_LOCK;
						st_next.mcnt = '0;
					end else begin
						do_step = 1'b1;
						st_next.rcnt = 26'(REP_CYC - 1);
					end
				end else if ((up_k ^ dn_k) && !st_reg.lock[st_reg.idx]) begin
					if (st_reg.rcnt == '0) begin
						do_step = 1'b1;
						st_next.rcnt = 26'(REP_CYC - 1);
					end else begin
						st_next.rcnt = st_reg.rcnt - 26'h1;
					end
				end
				if (do_step) begin
					st_next.edit = clamp_f(st_reg.idx, up_k
						? 8'(st_reg.edit + 8'h01) : 8'(st_reg.edit - 8'h01),
						st_reg.prm[`P_SP_FLOOR]);
				end
				if (press[`KEY_ACCEPT]) begin
					st_next.prm[st_reg.idx] = st_reg.edit;
					st_next.mcnt = '0;
					if (st_reg.idx == `P_DOOR_DLY) begin
						st_next.mode = M_RUN;
						st_next.unit_on = 1'b0;
					end else begin
						st_next.mode = M_NAME;
						st_next.idx = st_reg.idx + 4'h1;
					end
				end
			end
			M_LOCK: begin
				if (st_reg.mcnt == 28'(LOCK_CYC - 1)) begin
					st_next.mode = M_VALUE;
				end else begin
					st_next.mcnt = st_reg.mcnt + 28'h1;
				end
			end
		endcase
		// ------------------------------------------------------------
		// loads and display
		// ------------------------------------------------------------
		unique case (st_reg.prm[`P_LIGHT_SRC])
			8'h01: st_next.light = st_next.door;
			8'h02: st_next.light = st_next.lkey;
			8'h03: st_next.light = st_next.door | st_next.lkey;
			default: st_next.light = 1'b0;
		endcase
		unique case (st_reg.prm[`P_RELAY4])
			8'h01: st_next.rl4 = comp_demand & st_next.unit_on
				& ~st_next.alarm & ~st_next.door;
			8'h02: st_next.rl4 = st_next.unit_on & ~st_next.door;
			default: st_next.rl4 = 1'b0;
		endcase
		st_next.buzz = st_reg.buzz_fit & ((st_next.alarm & ~st_next.sil)
			| (st_next.bcnt != '0));
		st_next.ledf = st_next.mode != M_RUN && st_next.mode != M_HOLD;
		st_next.dflash = st_next.ledf
			|| (st_next.alarm && !st_next.sil);
		st_next.dval = '0;
		if (st_next.mode == M_LOCK) begin
			st_next.msg = MSG_LOCKED;
		end else if (st_next.mode == M_NAME) begin
			st_next.msg = MSG_NAME;
			st_next.dval = {4'h0, st_next.idx};
		end else if (st_next.mode == M_VALUE) begin
			st_next.msg = MSG_VALUE;
			st_next.dval = st_next.edit;
		end else if (!st_next.unit_on || st_next.mode == M_HOLD) begin
			st_next.msg = MSG_OFF;
		end else if (st_next.dr || st_next.alarm) begin
			st_next.msg = MSG_DOOR;
		end else begin
			st_next.msg = MSG_TEMP;
		end
		// ------------------------------------------------------------
		// register slave
		// ------------------------------------------------------------
		if (s_axi_awvalid && s_axi_awready) begin
			st_next.awv = 1'b1;
			st_next.awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_next.wv = 1'b1;
			st_next.wd = s_axi_wdata;
			st_next.ws = s_axi_wstrb;
		end
		if (st_reg.bv && s_axi_bready) begin
			st_next.bv = 1'b0;
		end
		if (st_reg.awv && st_reg.wv) begin
			st_next.awv = 1'b0;
			st_next.wv = 1'b0;
			st_next.bv = 1'b1;
			st_next.br = 2'h0;
			if (st_reg.awa == `REG_CTRL) begin
				if (st_reg.ws[0]) begin
					st_next.buzz_fit = st_reg.wd[`CTRL_BUZZ];
				end
			end else if (st_reg.awa == `REG_LOCK) begin
				if (st_reg.ws[0]) begin
					st_next.lock[7:0] = st_reg.wd[7:0];
				end
				if (st_reg.ws[1]) begin
					st_next.lock[15:8] = st_reg.wd[15:8];
				end
			end else if (st_reg.awa[7:6] == `REG_PARAM >> 6
				&& st_reg.awa[1:0] == 2'h0) begin
				if (st_reg.ws[0]) begin
					st_next.prm[st_reg.awa[5:2]] = clamp_f(st_reg.awa[5:2],
						st_reg.wd[7:0], st_reg.prm[`P_SP_FLOOR]);
				end
			end else if (st_reg.awa != `REG_STATUS) begin
				st_next.br = 2'h2;
			end
		end
		if (st_reg.rv && s_axi_rready) begin
			st_next.rv = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			st_next.rv = 1'b1;
			st_next.rr = 2'h0;
			st_next.rd = '0;
			if (s_axi_araddr == `REG_CTRL) begin
				st_next.rd[`CTRL_BUZZ] = st_reg.buzz_fit;
			end else if (s_axi_araddr == `REG_LOCK) begin
				st_next.rd[15:0] = st_reg.lock;
			end else if (s_axi_araddr == `REG_STATUS) begin
				st_next.rd = {18'h0, st_reg.mode, st_reg.idx, st_reg.unit_on,
					st_reg.sil, st_reg.alarm, st_reg.dr, st_reg.door};
			end else if (s_axi_araddr[7:6] == `REG_PARAM >> 6
				&& s_axi_araddr[1:0] == 2'h0) begin
				st_next.rd[7:0] = st_reg.prm[s_axi_araddr[5:2]];
			end else begin
				st_next.rr = 2'h2;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
			st_reg.mode <= M_RUN;
			st_reg.msg <= MSG_OFF;
			st_reg.buzz_fit <= `BUZZ_RST;
			st_reg.prm <= PRM_RST;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign fan_stop = st_reg.door;
	assign comp_off = st_reg.alarm;
	assign light_on = st_reg.light;
	assign relay4_on = st_reg.rl4;
	assign buzzer = st_reg.buzz;
	assign unit_on = st_reg.unit_on;
	assign disp_msg = st_reg.msg;
	assign disp_value = st_reg.dval;
	assign disp_flash = st_reg.dflash;
	assign led_flash = st_reg.ledf;
	assign s_axi_awready = ce & ~st_reg.awv & ~st_reg.bv;
	assign s_axi_wready = ce & ~st_reg.wv & ~st_reg.bv;
	assign s_axi_bvalid = st_reg.bv;
	assign s_axi_bresp = st_reg.br;
	assign s_axi_arready = ce & ~st_reg.rv;
	assign s_axi_rvalid = st_reg.rv;
	assign s_axi_rdata = st_reg.rd;
	assign s_axi_rresp = st_reg.rr;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	a_fan_door: assert property (st_reg.door |-> fan_stop)
		else $error("fan runs with door open");
	a_msg_time: assert property ($rose(st_reg.dr) |->
		st_reg.door && st_reg.open_s == 11'(`DR_SHOW_S))
		else $error("door message at wrong time");
	a_beep_msg: assert property ($rose(st_reg.dr) && st_reg.buzz_fit
		|-> buzzer)
		else $error("no beep with door message");
	a_alarm_comp: assert property (st_reg.alarm |-> comp_off && st_reg.door
		&& (st_reg.sil || disp_flash))
		else $error("alarm without compressor stop or flash");
	a_zero_delay: assert property ($rose(st_reg.door)
		&& $past(st_reg.prm[`P_DOOR_DLY]) == 8'h00 |-> st_reg.alarm)
		else $error("zero delay alarm late");
	a_key_silence: assert property (ce && st_reg.alarm && press[5:0] != '0
		&& door_now |=> st_reg.sil && (!buzzer || st_reg.bcnt != '0))
		else $error("alarm not silenced");
	a_close_clear: assert property ($fell(st_reg.door) |->
		!st_reg.alarm && !st_reg.dr && !comp_off)
		else $error("alarm kept after door close");
	a_hold_abort: assert property (ce && st_reg.mode == M_HOLD
		&& !(st_reg.stab[`KEY_POWER] && up_k && dn_k)
		|=> st_reg.mode == M_RUN)
		else $error("entry not abandoned");
	a_lock_refuse: assert property (ce && st_reg.mode == M_VALUE
		&& st_reg.lock[st_reg.idx] && press[`KEY_UP] |=>
		st_reg.mode == M_LOCK && disp_msg == MSG_LOCKED
		&& $stable(st_reg.edit))
		else $error("locked value changed");
	a_ceil_range: assert property (signed'(st_reg.prm[`P_SP_CEIL])
		<= signed'(`MAX_CEIL) && signed'(st_reg.prm[`P_DOOR_DLY])
		<= signed'(`MAX_DOOR_DLY))
		else $error("parameter out of range");
	c_door_alarm: cover property ($rose(st_reg.alarm) ##[1:1000] $fell(st_reg.door));
	c_entry: cover property ($rose(st_reg.mode == M_NAME));
	c_locked: cover property ($rose(st_reg.mode == M_LOCK));
	c_leave: cover property (st_reg.mode == M_VALUE ##1 st_reg.mode == M_RUN);
endmodule
`default_nettype wire
